// ==== design/sadc_device.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sadc_params.svh"
module sadc_device
    import sadc_pkg::*;
#(
    parameter int unsigned CAL_CYC = `SADC_CAL_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Analog stand-in: signed input sample, full-scale at +/-2^15
    input wire logic signed [16:0] i_sample,
    // Status
    output logic o_busy,
    output logic o_calibrating,
    // Link
    sadc_link_if.dev link
);
    localparam int unsigned W = `SADC_RES_W;
    localparam logic [`SADC_CNT_W-1:0] RECAL_N = `SADC_CNT_W'(`SADC_RECAL_PULSES - 1);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [1:0] cs_ff, sck_ff;
    logic cs_d_ff, sck_d_ff;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cs_ff <= 2'h3;
            sck_ff <= 2'h0;
            cs_d_ff <= 1'b1;
            sck_d_ff <= 1'b0;
        end else begin
            cs_ff <= {cs_ff[0], link.conversion_start_select};
            sck_ff <= {sck_ff[0], link.sclk};
            cs_d_ff <= cs_ff[1];
            sck_d_ff <= sck_ff[1];
        end
    end
    wire cs_rise = cs_ff[1] & ~cs_d_ff;
    wire cs_fall = ~cs_ff[1] & cs_d_ff;
    wire sck_rise = sck_ff[1] & ~sck_d_ff;
    wire sck_fall = ~sck_ff[1] & sck_d_ff;

    // ----------------------------------------
    // Conversion transfer (saturating two's complement)
    // ----------------------------------------
    function automatic sadc_word_t quantize(input logic signed [16:0] s);
        logic signed [16:0] lim;
        lim = s;
        if (s > 17'sh07FFF) begin
            lim = 17'sh07FFF;
        end else if (s < -17'sh08000) begin
            lim = -17'sh08000;
        end
        // Keep top W bits; MSB is the sign
        quantize = sadc_word_t'(lim[15:0] >> (16 - W)) << (16 - W);
    endfunction

    // ----------------------------------------
    // Phase control
    // ----------------------------------------
    sadc_dev_e phase_ff;
    logic [31:0] tmr_ff;
    sadc_word_t conv_ff, shreg_ff;
    logic [4:0] left_ff;
    logic drive_ff;
    logic [`SADC_CNT_W-1:0] pulse_ff;
    logic armed_ff;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            phase_ff <= SADC_ACQ;
            tmr_ff <= 32'h0;
            conv_ff <= 16'h0;
        end else begin
            unique case (phase_ff)
                SADC_ACQ: begin
                    if (pulse_ff == RECAL_N && sck_rise) begin
                        phase_ff <= SADC_CAL;
                        tmr_ff <= 32'h0;
                    end else if (cs_rise) begin
                        conv_ff <= quantize(i_sample);
                        phase_ff <= SADC_CONV;
                        tmr_ff <= 32'h0;
                    end
                end
                SADC_CONV: begin
                    // Start line ignored until done
                    tmr_ff <= tmr_ff + 32'h1;
                    if (tmr_ff == 32'(`SADC_CONV_CYC - 2)) begin
                        phase_ff <= SADC_ACQ;
                    end
                end
                SADC_CAL: begin
                    tmr_ff <= tmr_ff + 32'h1;
                    if (tmr_ff == CAL_CYC - 1) begin
                        phase_ff <= SADC_ACQ;
                    end
                end
            endcase
        end
    end

    // Result becomes readable only once conversion ends
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            armed_ff <= 1'b0;
        end else if (phase_ff == SADC_CONV && tmr_ff == 32'(`SADC_CONV_CYC - 2)) begin
            armed_ff <= 1'b1;
        end else if (cs_fall && phase_ff == SADC_ACQ) begin
            armed_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // Readout shifter, runs during acquisition
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            shreg_ff <= 16'h0;
            left_ff <= 5'h0;
            drive_ff <= 1'b0;
        end else if (cs_ff[1] || phase_ff != SADC_ACQ) begin
            drive_ff <= 1'b0;
            left_ff <= 5'h0;
        end else if (cs_fall && armed_ff) begin
            shreg_ff <= conv_ff;
            left_ff <= 5'(W);
            drive_ff <= 1'b1;
        end else if (sck_fall && drive_ff) begin
            shreg_ff <= {shreg_ff[14:0], 1'b0};
            left_ff <= left_ff - 5'h1;
            if (left_ff == 5'h1) begin
                drive_ff <= 1'b0;
            end
        end
    end

    // Count sclk rises while selected in standby
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || cs_ff[1] || phase_ff != SADC_ACQ) begin
            pulse_ff <= '0;
        end else if (sck_rise && pulse_ff != RECAL_N) begin
            pulse_ff <= pulse_ff + `SADC_CNT_W'(1);
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Calibration drives low, so a pull-up shows completion
    assign link.sdo_oe = drive_ff | (phase_ff == SADC_CAL);
    assign link.sdo_o = (phase_ff == SADC_CAL) ? 1'b0 : shreg_ff[15];
    assign o_busy = (phase_ff == SADC_CONV);
    assign o_calibrating = (phase_ff == SADC_CAL);
endmodule
`default_nettype wire

// ==== design/sadc_host.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sadc_params.svh"
module sadc_host
    import sadc_pkg::*;
#(
    parameter int unsigned CAL_CYC = `SADC_CAL_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // User requests
    input wire logic i_read,
    input wire logic i_recal,
    output logic o_ready,
    // User results
    output sadc_word_t o_data,
    output logic o_data_valid,
    output logic o_cal_done,
    // Link
    sadc_link_if.host link
);
    localparam int unsigned W = `SADC_RES_W;

    sadc_host_e st_ff;
    logic [31:0] cnt_ff;
    logic [2:0] div_ff;
    logic sck_ff, cs_ff, recal_ff;
    logic [10:0] edges_ff;
    sadc_word_t rx_ff;
    logic [1:0] sdo_sync_ff;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sdo_sync_ff <= 2'h3;
        end else begin
            sdo_sync_ff <= {sdo_sync_ff[0], link.sdo_line};
        end
    end

    // Divider enable for the serial clock
    wire tick = (div_ff == 3'(`SADC_SCLK_HALF - 1));
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || st_ff != SADC_H_SHIFT || tick) begin
            div_ff <= 3'h0;
        end else begin
            div_ff <= div_ff + 3'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_ff <= SADC_H_IDLE;
            cnt_ff <= 32'h0;
            sck_ff <= 1'b0;
            cs_ff <= 1'b1;
            recal_ff <= 1'b0;
            edges_ff <= 11'h0;
            rx_ff <= 16'h0;
            o_data <= 16'h0;
            o_data_valid <= 1'b0;
            o_cal_done <= 1'b0;
        end else begin
            o_data_valid <= 1'b0;
            o_cal_done <= 1'b0;
            unique case (st_ff)
                SADC_H_IDLE: begin
                    // Select idles low so each request makes a fresh start edge
                    if ((i_read || i_recal) && !cs_ff) begin
                        cs_ff <= 1'b1;
                        recal_ff <= i_recal & ~i_read;
                        cnt_ff <= 32'h0;
                        st_ff <= SADC_H_CONV;
                    end else begin
                        cs_ff <= 1'b0;
                    end
                end
                SADC_H_CONV: begin
                    // Hold high through conversion plus sync margin
                    cnt_ff <= cnt_ff + 32'h1;
                    if (cnt_ff == 32'(`SADC_CONV_CYC + 3)) begin
                        cs_ff <= 1'b0;
                        edges_ff <= 11'h0;
                        cnt_ff <= 32'h0;
                        st_ff <= SADC_H_SHIFT;
                    end
                end
                SADC_H_SHIFT: begin
                    if (tick) begin
                        sck_ff <= ~sck_ff;
                        if (sck_ff) begin
                            // Capture as sclk falls: the bit moved on the previous
                            // fall has crossed both synchroniser chains by now
                            if (edges_ff < 11'(W)) begin
                                rx_ff <= {rx_ff[14:0], sdo_sync_ff[1]};
                            end
                            edges_ff <= edges_ff + 11'h1;
                            if (edges_ff == 11'(W - 1) && !recal_ff) begin
                                st_ff <= SADC_H_QUIET;
                            end else if (edges_ff == 11'(`SADC_RECAL_PULSES - 1)) begin
                                st_ff <= SADC_H_CALW;
                            end
                        end
                    end
                end
                SADC_H_QUIET: begin
                    // Quiet gap before the next start edge
                    cnt_ff <= cnt_ff + 32'h1;
                    if (cnt_ff == 32'(`SADC_QUIET_CYC + 3)) begin
                        o_data <= rx_ff;
                        o_data_valid <= 1'b1;
                        cnt_ff <= 32'h0;
                        st_ff <= SADC_H_IDLE;
                    end
                end
                SADC_H_CALW: begin
                    cs_ff <= 1'b1;
                    cnt_ff <= cnt_ff + 32'h1;
                    // Wait for the pulled-up line to rise
                    if (cnt_ff > 32'h8 && sdo_sync_ff[1]) begin
                        o_cal_done <= 1'b1;
                        st_ff <= SADC_H_IDLE;
                    end
                end
            endcase
        end
    end

    // Not ready until select has been low, else no start edge follows
    assign o_ready = (st_ff == SADC_H_IDLE) && !cs_ff;
    assign link.sclk = sck_ff;
    assign link.conversion_start_select = cs_ff;
    assign link.sdi = 1'b1;
endmodule
`default_nettype wire

// ==== design/sadc_link_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface sadc_link_if;
    logic conversion_start_select;
    logic sclk;
    logic sdi;
    logic sdo_o;
    logic sdo_oe;
    logic sdo_line;
    // Line pulled up outside: undriven reads high
    assign sdo_line = sdo_oe ? sdo_o : 1'b1;
    modport dev (
        input conversion_start_select, sclk, sdi, sdo_line,
        output sdo_o, sdo_oe
    );
    modport host (
        output conversion_start_select, sclk, sdi,
        input sdo_line, sdo_oe
    );
endinterface
`default_nettype wire

// ==== design/sadc_params.svh ====
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH
// Result width of the variant built here (16, 14 or 12)
`define SADC_RES_W 16
`define SADC_CNT_W 11
// Clock rate in MHz and documented times
`define SADC_CLK_MHZ 40
`define SADC_CONV_TIME_NS 710
`define SADC_QUIET_NS 10
`define SADC_CAL_MS 500
// Cycle counts derived from times: least times round up
`define SADC_CONV_CYC ((`SADC_CONV_TIME_NS * `SADC_CLK_MHZ + 999) / 1000)
`define SADC_QUIET_CYC (((`SADC_QUIET_NS * `SADC_CLK_MHZ + 999) / 1000) < 1 ? 1 : \
    ((`SADC_QUIET_NS * `SADC_CLK_MHZ + 999) / 1000))
`define SADC_CAL_CYC (`SADC_CAL_MS * 1000 * `SADC_CLK_MHZ)
// Serial clocks that form the recalibrate command
`define SADC_RECAL_PULSES 1024
// Host serial clock half period in system cycles; four covers the
// synchroniser delay at both ends before the host captures a bit
`define SADC_SCLK_HALF 4
`endif

// ==== design/sadc_pkg.sv ====
package sadc_pkg;
    typedef logic [15:0] sadc_word_t;
    typedef enum logic [1:0] {
        SADC_ACQ = 2'b00,
        SADC_CONV = 2'b01,
        SADC_CAL = 2'b11
    } sadc_dev_e;
    typedef enum logic [2:0] {
        SADC_H_IDLE = 3'b000,
        SADC_H_CONV = 3'b001,
        SADC_H_SHIFT = 3'b011,
        SADC_H_QUIET = 3'b010,
        SADC_H_CALW = 3'b110
    } sadc_host_e;
endpackage

// ==== test/sadc_link_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module sadc_link_properties (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Link wires
    input wire logic conversion_start_select,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo_o,
    input wire logic sdo_oe
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic sclk_d_ff;
    logic [10:0] rise_cnt_ff;
    logic [4:0] fall_cnt_ff;
    logic [2:0] fall_age_ff;
    logic [5:0] hi_cnt_ff;
    // Edge counts restart whenever select is high
    always_ff @(posedge i_clk) begin
        sclk_d_ff <= sclk;
        if (!i_rst_n || conversion_start_select) begin
            rise_cnt_ff <= 11'h000;
            fall_cnt_ff <= 5'h00;
        end else begin
            if (sclk && !sclk_d_ff && rise_cnt_ff != 11'h7FF) begin
                rise_cnt_ff <= rise_cnt_ff + 11'h001;
            end
            if (!sclk && sclk_d_ff && fall_cnt_ff != 5'h1F) begin
                fall_cnt_ff <= fall_cnt_ff + 5'h01;
            end
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            fall_age_ff <= 3'h7;
        end else if (!sclk && sclk_d_ff) begin
            fall_age_ff <= 3'h0;
        end else if (fall_age_ff != 3'h7) begin
            fall_age_ff <= fall_age_ff + 3'h1;
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            hi_cnt_ff <= 6'h3F;
        end else if (!conversion_start_select) begin
            hi_cnt_ff <= 6'h00;
        end else if (hi_cnt_ff != 6'h3F) begin
            hi_cnt_ff <= hi_cnt_ff + 6'h01;
        end
    end
    property p_sdi_high;
        sdi == 1'b1;
    endproperty
    a_sdi_high: assert property (p_sdi_high) else $error("sdi not high");
    property p_quiet;
        $rose(conversion_start_select) |-> !sclk && !sclk_d_ff;
    endproperty
    a_quiet: assert property (p_quiet) else $error("no quiet gap");
    property p_conv_time;
        $fell(conversion_start_select) |-> hi_cnt_ff >= 6'h1D;
    endproperty
    a_conv_time: assert property (p_conv_time) else $error("select low too soon");
    property p_read_len;
        $rose(conversion_start_select) && rise_cnt_ff < 11'h400
            |-> rise_cnt_ff inside {11'h000, 11'h010};
    endproperty
    a_read_len: assert property (p_read_len) else $error("bad clock count");
    property p_shift_edge;
        $changed(sdo_o) && sdo_oe && $past(sdo_oe) |-> fall_age_ff inside {[1:4]};
    endproperty
    a_shift_edge: assert property (p_shift_edge) else $error("sdo moved off fall");
    property p_release_last;
        fall_cnt_ff == 5'h10 && fall_age_ff == 3'h5 |-> !sdo_oe;
    endproperty
    a_release_last: assert property (p_release_last) else $error("sdo held");
    property p_release_rise;
        $rose(conversion_start_select) && rise_cnt_ff < 11'h400 |-> ##[1:5] !sdo_oe;
    endproperty
    a_release_rise: assert property (p_release_rise) else $error("sdo kept");
    property p_cal_low;
        rise_cnt_ff == 11'h400 && $changed(rise_cnt_ff) |-> ##[1:8] (sdo_oe && !sdo_o);
    endproperty
    a_cal_low: assert property (p_cal_low) else $error("cal not low");
endmodule
`default_nettype wire

// ==== test/tb_sar_adc_serial_readout.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_sar_adc_serial_readout import sadc_pkg::*;;
    // Short calibration keeps the run brief
    localparam int unsigned CAL_CYC = 200;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic signed [16:0] i_sample = 17'h00000;
    logic i_read = 1'b0;
    logic i_recal = 1'b0;
    logic o_busy, o_calibrating, o_ready, o_data_valid, o_cal_done;
    logic [3:0] flags;
    sadc_word_t o_data;
    sadc_word_t exp_q[$];
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    int n;
    logic [31:0] lfsr_ff = 32'h230B;
    logic [16:0] corner [9] = '{17'h10000, 17'h17FFF, 17'h18000, 17'h1FFFF, 17'h00000,
        17'h00001, 17'h07FFF, 17'h08000, 17'h0FFFF};
    assign flags = {o_cal_done, o_calibrating, o_data_valid, o_ready};
    sadc_link_if link_if ();
    sadc_device #(.CAL_CYC(CAL_CYC)) u_sadc_device (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_sample(i_sample), .o_busy(o_busy), .o_calibrating(o_calibrating), .link(link_if.dev));
    sadc_host #(.CAL_CYC(CAL_CYC)) u_sadc_host (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_read(i_read), .i_recal(i_recal), .o_ready(o_ready), .o_data(o_data),
        .o_data_valid(o_data_valid), .o_cal_done(o_cal_done), .link(link_if.host));
    sadc_link_properties u_sadc_link_properties (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .conversion_start_select(link_if.conversion_start_select), .sclk(link_if.sclk),
        .sdi(link_if.sdi), .sdo_o(link_if.sdo_o), .sdo_oe(link_if.sdo_oe));
    always #12.5 i_clk = ~i_clk;
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Model: clamp to the 16-bit two's complement range
    function automatic sadc_word_t sat_code(input int s);
        if (s > 32767) begin
            return 16'h7FFF;
        end
        if (s < -32768) begin
            return 16'h8000;
        end
        return s[15:0];
    endfunction
    task automatic check(input sadc_word_t got, input sadc_word_t exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wait_sig(input int which, input int lim);
        n = 0;
        while (flags[which] !== 1'b1 && n < lim) begin
            @(negedge i_clk);
            n++;
        end
        check({15'h0000, flags[which]}, 16'h0001, "handshake");
    endtask
    task automatic read_one(input logic signed [16:0] s);
        wait_sig(0, 400);
        i_sample = s;
        exp_q.push_back(sat_code(int'(s)));
        i_read = 1'b1;
        @(negedge i_clk);
        i_read = 1'b0;
        repeat (3) @(negedge i_clk);
        check({15'h0000, o_busy}, 16'h0001, "busy");
        wait_sig(1, 400);
        check(o_data, exp_q.pop_front(), "result");
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        repeat (6) @(negedge i_clk);
        i_rst_n = 1'b1;
        @(negedge i_clk);
        foreach (corner[i]) begin
            read_one(corner[i]);
        end
        repeat (20) begin
            lfsr_ff = lfsr_next(lfsr_ff);
            read_one(lfsr_ff[16:0]);
        end
        wait_sig(0, 400);
        i_recal = 1'b1;
        @(negedge i_clk);
        i_recal = 1'b0;
        wait_sig(2, 9000);
        check({15'h0000, link_if.sdo_line}, 16'h0000, "cal level");
        wait_sig(3, 6000);
        check(16'(n >= CAL_CYC - 10 && n <= CAL_CYC + 10), 16'h0001, "cal length");
        repeat (4) @(negedge i_clk);
        check({15'h0000, link_if.sdo_line}, 16'h0001, "cal release");
        read_one(17'h1F000);
        stop_test();
    end
endmodule
`default_nettype wire
